/* hdl/lcc_top.sv */
// Purpose: logic cell cascade chain and counter cell, set up over classic Wishbone
// Assumes: 250 MHz clk_in; chip_wide_reset_n_in is asynchronous to it
// Notes: no interrupts, no buffering, single clock domain
//
// Overview of operation
// - cascade joins adjacent cell outputs by AND, or OR through input/output inversion
// - each further cell in the chain adds four inputs to fan-in
// - chains longer than ten cells continue into further clusters
// - inter-cluster hops go even to next even, odd to next odd; here the last even cluster hops on to the first odd one
// - counter mode: one 3-input table for data, one for fast carry
// - two-way select gives synchronous load; gating AND gives synchronous clear
// - synchronous clear or load overrides the cascade value in counter mode
// - clear and load together: register clears, load ignored
// - arithmetic mode drives both registered and combinational table result
// - cluster-wide clear/preset drive the register; native asynchronous clear (here clear passes two synchroniser flops and acts on a clock edge)
// - emulated preset-and-load registers come up undefined after reset
// - chip-wide reset resets the count and cascade registers only; ctrl, table masks and load value keep their values
// - chip-wide reset overrides every other register control
// - preset registers go to one under chip-wide reset
// - chip-wide reset acts only when the build-time option enables it
//
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/1ps
module lcc_top #(
   parameter bit CHIP_RESET_ENABLE = 1'b1
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic chip_wide_reset_n_in,
   input wire logic cluster_clear_in,
   input wire logic cluster_preset_in,
   input wire logic [lcc_pkg::LCC_CHAIN_FANIN-1:0] chain_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   output logic wb_err_out,
   output logic chain_out,
   output logic [lcc_pkg::LCC_CNT_W-1:0] count_reg_out,
   output logic count_comb_out,
   output logic carry_out
);
   import lcc_pkg::*;

   // ----------------------------------------
   // reset and pin synchronisers
   // ----------------------------------------
   logic [1:0] rst_sync;
   logic rst_n;
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // chip reset passes two flops; stage one is read only by stage two
   logic [1:0] dev_sync;
   logic [1:0] clr_sync;
   logic [1:0] pre_sync;
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         dev_sync <= 2'b11;
         clr_sync <= 2'b00;
         pre_sync <= 2'b00;
      end else begin
         dev_sync <= {dev_sync[0], chip_wide_reset_n_in};
         clr_sync <= {clr_sync[0], cluster_clear_in};
         pre_sync <= {pre_sync[0], cluster_preset_in};
      end
   end
   logic chip_rst;
   // active low pin, gated by build-time option
   assign chip_rst = CHIP_RESET_ENABLE && !dev_sync[1];

   // ----------------------------------------
   // functions
   // ----------------------------------------
   // 3-input table lookup, used for data and carry tables
   function automatic logic lut3(input logic [7:0] mask, input logic [2:0] sel);
      lut3 = mask[sel];
   endfunction

   // one cell: four-input AND stage, chained with the incoming value
   function automatic logic cell_and(input logic [3:0] ins, input logic casc);
      cell_and = (&ins) & casc;
   endfunction

   // ----------------------------------------
   // cascade chain
   // ----------------------------------------
   // cells run serially; order visits even clusters, then odd ones
   logic or_mode;
   logic [LCC_CLUSTERS*LCC_CELLS:0] link;
   logic [LCC_CHAIN_FANIN-1:0] chain_pol;
   assign chain_pol = or_mode ? ~chain_in : chain_in;
   always_comb begin
      int c;
      int k;
      int ord;
      c = 0;
      k = 0;
      ord = 0;
      link = '0;
      link[0] = 1'b1;
      for (int step = 0; step < LCC_CLUSTERS; step++) begin
         // even clusters first, then odd; hops within each run skip one cluster
         c = (step < LCC_CLUSTERS/2) ? 2*step : 2*(step - LCC_CLUSTERS/2) + 1;
         for (k = 0; k < LCC_CELLS; k++) begin
            ord = step*LCC_CELLS + k;
            link[ord+1] = cell_and(chain_pol[(c*LCC_CELLS+k)*LCC_FANIN_PER_CELL +: LCC_FANIN_PER_CELL],
                                   link[ord]);
         end
      end
   end
   logic casc_val;
   assign casc_val = or_mode ? ~link[LCC_CLUSTERS*LCC_CELLS] : link[LCC_CLUSTERS*LCC_CELLS];

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [31:0] ctrl;
      logic [7:0] data_mask;
      logic [7:0] carry_mask;
      logic [LCC_CNT_W-1:0] load_val;
      logic [LCC_CNT_W-1:0] cnt;
      logic casc_q;
      lcc_bus_t bus;
      logic [31:0] rdata;
      logic err;
   } lcc_state_t;
   lcc_state_t st;
   lcc_state_t next_st;

   logic cnt_en;
   logic sclr;
   logic sload;
   logic casc_use;
   logic preset_mode;
   logic emul;
   assign or_mode = st.ctrl[LCC_CTRL_OR_BIT];
   assign cnt_en = st.ctrl[LCC_CTRL_CNT_EN_BIT];
   assign sclr = st.ctrl[LCC_CTRL_SCLR_BIT];
   assign sload = st.ctrl[LCC_CTRL_SLOAD_BIT];
   assign casc_use = st.ctrl[LCC_CTRL_CASC_USE_BIT];
   assign preset_mode = st.ctrl[LCC_CTRL_PRESET_BIT];
   assign emul = st.ctrl[LCC_CTRL_EMUL_BIT];

   // ----------------------------------------
   // counter cell bit 0 tables, ripple for the rest
   // ----------------------------------------
   logic [2:0] lut_sel;
   logic lut_data;
   logic lut_carry;
   assign lut_sel = {cnt_en, st.cnt[0], 1'b1};
   assign lut_data = lut3(st.data_mask, lut_sel);
   assign lut_carry = lut3(st.carry_mask, lut_sel);
   logic [LCC_CNT_W-1:0] cnt_inc;
   assign cnt_inc = {st.cnt[LCC_CNT_W-1:1] + {{(LCC_CNT_W-2){1'b0}}, lut_carry}, lut_data};

   logic [LCC_CNT_W-1:0] cnt_d;
   always_comb begin
      // clear gate after load select, so clear beats load and both beat cascade
      cnt_d = casc_use ? {{(LCC_CNT_W-1){1'b0}}, casc_val} : cnt_inc;
      cnt_d = sload ? st.load_val : cnt_d;
      cnt_d = cnt_d & {LCC_CNT_W{~sclr}};
   end

   // ----------------------------------------
   // bus and next state
   // ----------------------------------------
   logic req;
   logic hit;
   assign req = wb_cyc_in && wb_stb_in;
   assign hit = wb_adr_in == LCC_CTRL_OFS || wb_adr_in == LCC_CASC_OFS || wb_adr_in == LCC_CNT_OFS
             || wb_adr_in == LCC_LOAD_OFS || wb_adr_in == LCC_STAT_OFS;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      merge = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            merge[8*b +: 8] = nw[8*b +: 8];
         end
      end
   endfunction

   always_comb begin
      logic [31:0] w;
      w = 32'h0000_0000;
      next_st = st;
      next_st.casc_q = casc_val;
      next_st.cnt = cnt_d;
      // cluster controls: preset then native async-style clear
      if (pre_sync[1]) begin
         next_st.cnt = LCC_CNT_PRESET[LCC_CNT_W-1:0];
      end
      if (clr_sync[1]) begin
         next_st.cnt = '0;
      end
      case (st.bus)
         LCC_IDLE: begin
            if (req) begin
               next_st.bus = LCC_ACK;
               next_st.err = !hit;
               next_st.rdata = LCC_ERR_DATA;
               case (wb_adr_in)
                  LCC_CTRL_OFS: begin
                     next_st.rdata = st.ctrl;
                  end
                  LCC_CASC_OFS: begin
                     next_st.rdata = {16'h0000, st.carry_mask, st.data_mask};
                  end
                  LCC_CNT_OFS: begin
                     next_st.rdata = {16'h0000, st.cnt};
                  end
                  LCC_LOAD_OFS: begin
                     next_st.rdata = {16'h0000, st.load_val};
                  end
                  LCC_STAT_OFS: begin
                     next_st.rdata = {30'h0000_0000, st.casc_q, lut_carry};
                  end
                  default: begin
                     next_st.rdata = LCC_ERR_DATA;
                  end
               endcase
               if (wb_we_in && hit) begin
                  case (wb_adr_in)
                     LCC_CTRL_OFS: begin
                        next_st.ctrl = merge(st.ctrl, wb_dat_in, wb_sel_in);
                     end
                     LCC_CASC_OFS: begin
                        w = merge({16'h0000, st.carry_mask, st.data_mask}, wb_dat_in, wb_sel_in);
                        next_st.data_mask = w[7:0];
                        next_st.carry_mask = w[15:8];
                     end
                     LCC_LOAD_OFS: begin
                        w = merge({16'h0000, st.load_val}, wb_dat_in, wb_sel_in);
                        next_st.load_val = w[LCC_CNT_W-1:0];
                     end
                     default: begin
                        next_st.ctrl = st.ctrl;
                     end
                  endcase
               end
            end
         end
         LCC_ACK: begin
            next_st.bus = LCC_IDLE;
            next_st.err = 1'b0;
         end
         default: begin
            next_st.bus = LCC_IDLE;
         end
      endcase
      // chip reset last: beats enable, clears, preset and load
      if (chip_rst) begin
         next_st.cnt = preset_mode ? LCC_CNT_PRESET[LCC_CNT_W-1:0] : LCC_CNT_RESET[LCC_CNT_W-1:0];
         if (emul) begin
            next_st.cnt = LCC_UNDEF_FILL[LCC_CNT_W-1:0];
         end
         next_st.casc_q = 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         st <= '{ctrl: LCC_CTRL_RESET, data_mask: 8'h00, carry_mask: 8'h00, load_val: '0,
                 cnt: '0, casc_q: 1'b0, bus: LCC_IDLE, rdata: 32'h0000_0000, err: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign wb_ack_out = (st.bus == LCC_ACK) && !st.err;
   assign wb_err_out = (st.bus == LCC_ACK) && st.err;
   assign wb_dat_out = st.rdata;
   assign chain_out = st.casc_q;
   assign count_reg_out = st.cnt;
   assign count_comb_out = lut_data;
   assign carry_out = lut_carry;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n);

   clear_wins_a: assert property (sclr && !chip_rst && !clr_sync[1] && !pre_sync[1] |=> st.cnt == '0)
      else $error("sync clear did not clear");
   load_applies_a: assert property (sload && !sclr && !chip_rst && !clr_sync[1] && !pre_sync[1]
                                    |=> st.cnt == $past(st.load_val))
      else $error("sync load not applied");
   cascade_over_a: assert property (casc_use && sload && !sclr && !chip_rst && !clr_sync[1] && !pre_sync[1]
                                    |=> st.cnt == $past(st.load_val))
      else $error("cascade overrode load");
   chip_preset_a: assert property (chip_rst && preset_mode && !emul |=> st.cnt == LCC_CNT_PRESET[LCC_CNT_W-1:0])
      else $error("preset register not set by chip reset");
   chip_reset_a: assert property (chip_rst && !preset_mode && !emul |=> st.cnt == '0 && !st.casc_q)
      else $error("chip reset did not reset");
   cluster_clear_a: assert property (clr_sync[1] && !chip_rst |=> st.cnt == '0)
      else $error("cluster clear ignored");
   chain_and_a: assert property (!or_mode && (&chain_in) && !chip_rst |=> chain_out)
      else $error("and chain wrong");
   chain_or_a: assert property (or_mode && chain_in == '0 && !chip_rst |=> !chain_out)
      else $error("or chain wrong");
   // disabled build: a low pin must not clear the cascade register
   pin_gate_a: assert property (!CHIP_RESET_ENABLE && !dev_sync[1] |=> chain_out == $past(casc_val))
      else $error("reset acted while disabled");
   ack_pulse_a: assert property (req && st.bus == LCC_IDLE |=> (wb_ack_out || wb_err_out) ##1 !(wb_ack_out || wb_err_out))
      else $error("bus answer not one cycle");
   comb_out_a: assert property (cnt_en && !sload && !sclr && !casc_use && !chip_rst && !clr_sync[1] && !pre_sync[1]
                                |=> st.cnt[0] == $past(count_comb_out))
      else $error("registered bit differs from combinational output");

   load_cv: cover property (sload && !sclr);
   both_cv: cover property (sload && sclr);
   chip_cv: cover property (chip_rst && preset_mode);
   orch_cv: cover property (or_mode && chain_out);
endmodule

/* hdl/lcc_pkg.sv */
// Purpose: constants and types for the logic cell cascade/counter block
// Assumes: one clock, register bus carries ctrl, table mask and load writes as well as status reads
// Notes: offsets are byte addresses on a 32-bit classic bus
package lcc_pkg;
   // ----------------------------------------
   // geometry
   // ----------------------------------------
   localparam int LCC_CELLS = 10;
   localparam int LCC_CLUSTERS = 4;
   localparam int LCC_FANIN_PER_CELL = 4;
   localparam int LCC_CHAIN_FANIN = LCC_CELLS * LCC_CLUSTERS * LCC_FANIN_PER_CELL;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] LCC_CTRL_OFS = 8'h00;
   localparam logic [7:0] LCC_CASC_OFS = 8'h04;
   localparam logic [7:0] LCC_CNT_OFS = 8'h08;
   localparam logic [7:0] LCC_LOAD_OFS = 8'h0c;
   localparam logic [7:0] LCC_STAT_OFS = 8'h10;
   // ctrl fields
   localparam int LCC_CTRL_OR_BIT = 0;
   localparam int LCC_CTRL_CNT_EN_BIT = 1;
   localparam int LCC_CTRL_SCLR_BIT = 2;
   localparam int LCC_CTRL_SLOAD_BIT = 3;
   localparam int LCC_CTRL_CASC_USE_BIT = 4;
   localparam int LCC_CTRL_PRESET_BIT = 5;
   localparam int LCC_CTRL_EMUL_BIT = 6;
   localparam logic [31:0] LCC_CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] LCC_CNT_RESET = 32'h0000_0000;
   localparam logic [31:0] LCC_CNT_PRESET = 32'hffff_ffff;
   localparam logic [31:0] LCC_UNDEF_FILL = 32'hdead_beef;
   localparam int LCC_CNT_W = 16;
   localparam logic [31:0] LCC_ERR_DATA = 32'h0000_0000;
   typedef enum logic [1:0] {
      LCC_IDLE = 2'b00,
      LCC_ACK = 2'b01
   } lcc_bus_t;
endpackage

/* test/tb_lcc_top.sv */
// Purpose: self-checking bench for the cascade chain and counter cell block
// Assumes: bus answers one cycle after a request is taken; outputs read at clock edges
// Notes: a second copy has the chip reset pin disabled, to show it is ignored there
`timescale 1ns/1ps
module tb_lcc_top;
   import lcc_pkg::*;
   logic clk_in, reset_n_in, chip_rst_n, clr, pre, cyc, stb, we, ack, err;
   logic cho, cmb, cry, cho2, re, orm, en;
   logic [LCC_CHAIN_FANIN-1:0] chain, v;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, rq, ld, tb, ctl, dummy;
   logic [15:0] cnt, cnt2, exp_cnt, post, post2;
   int error_cnt, tests_run, pos;
   lcc_top #(.CHIP_RESET_ENABLE(1'b1)) u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
      .chip_wide_reset_n_in(chip_rst_n), .cluster_clear_in(clr), .cluster_preset_in(pre),
      .chain_in(chain), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
      .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .wb_err_out(err),
      .chain_out(cho), .count_reg_out(cnt), .count_comb_out(cmb), .carry_out(cry));
   lcc_top #(.CHIP_RESET_ENABLE(1'b0)) u_dut_nr (.clk_in(clk_in), .reset_n_in(reset_n_in),
      .chip_wide_reset_n_in(chip_rst_n), .cluster_clear_in(clr), .cluster_preset_in(pre),
      .chain_in(chain), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
      .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(), .wb_ack_out(), .wb_err_out(),
      .chain_out(cho2), .count_reg_out(cnt2), .count_comb_out(), .carry_out());
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkb(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask
   // called right after a rising edge; holds the request until ack or err is sampled
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      do begin
         @(posedge clk_in);
         n++;
      end while (ack !== 1'b1 && err !== 1'b1 && n < 16);
      q = rdat;
      e = err;
      chkb(ack | err, 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      bus(1'b1, a, d, q, e);
   endtask
   // comparisons happen in the edge's time step, before that edge's updates land
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   function automatic logic casc_exp(input logic [LCC_CHAIN_FANIN-1:0] x, input logic o);
      return o ? |x : &x;
   endfunction
   function automatic logic tbl(input logic [7:0] t, input logic e, input logic b0);
      return t[{e, b0, 1'b1}];
   endfunction
   // ----------------------------------------
   // clock, watchdog, tests
   // ----------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   initial begin
      #200000;
      error_cnt++;
      test_done();
   end
   initial begin
      reset_n_in = 1'b0;
      chip_rst_n = 1'b1;
      {clr, pre, cyc, stb, we} = 5'h0;
      chain = '0;
      adr = 8'h00;
      sel = 4'h0;
      wdat = 32'h0;
      error_cnt = 0;
      tests_run = 0;
      dummy = $urandom(32'h4cbb);
      tick(2);
      reset_n_in <= 1'b1;
      tick(3);
      bus(1'b0, LCC_CTRL_OFS, 32'h0, rq, re);
      chk(rq, LCC_CTRL_RESET);
      bus(1'b0, LCC_CNT_OFS, 32'h0, rq, re);
      chk(rq, LCC_CNT_RESET);
      bus(1'b0, 8'h20, 32'h0, rq, re);
      chkb(re, 1'b1);
      chk(rq, LCC_ERR_DATA);
      $display("test register access done");
      for (int i = 0; i < 80; i++) begin
         orm = i[0];
         wr(LCC_CTRL_OFS, {31'h0, orm});
         pos = (i < 40) ? i * 4 + (i[0] ? 3 : 0) : $urandom_range(LCC_CHAIN_FANIN - 1);
         v = orm ? '0 : '1;
         if (i % 5 != 4) v[pos] = ~orm;
         chain <= v;
         tick(3);
         chkb(cho, casc_exp(v, orm));
      end
      bus(1'b0, LCC_STAT_OFS, 32'h0, rq, re);
      chkb(rq[1], casc_exp(v, orm));
      $display("test cascade chain done");
      for (int i = 0; i < 8; i++) begin
         tb = $urandom();
         ld = $urandom();
         en = i[0];
         chain <= i[1] ? '1 : '0;
         wr(LCC_CASC_OFS, {16'h0, tb[15:0]});
         wr(LCC_LOAD_OFS, ld);
         wr(LCC_CTRL_OFS, {27'h0, i[1], 2'b10, en, 1'b0});
         tick(3);
         chk({16'h0, cnt}, {16'h0, ld[15:0]});
         chkb(cmb, tbl(tb[7:0], en, ld[0]));
         chkb(cry, tbl(tb[15:8], en, ld[0]));
         bus(1'b0, LCC_STAT_OFS, 32'h0, rq, re);
         chkb(rq[0], tbl(tb[15:8], en, ld[0]));
         wr(LCC_CTRL_OFS, {27'h0, i[1], 2'b11, en, 1'b0});
         tick(3);
         chk({16'h0, cnt}, 32'h0);
         chkb(cmb, tbl(tb[7:0], en, 1'b0));
      end
      // data table toggles bit 0, carry table fires on bit 0 set: plain binary count
      wr(LCC_CASC_OFS, 32'h0000_8020);
      wr(LCC_CTRL_OFS, 32'h0000_0002);
      tick(2);
      exp_cnt = cnt + 16'h0001;
      tick(1);
      chk({16'h0, cnt}, {16'h0, exp_cnt});
      $display("test counter mode done");
      for (int m = 0; m < 3; m++) begin
         ld = $urandom();
         ctl = (m == 0) ? 32'h08 : (m == 1) ? 32'h2c : 32'h48;
         exp_cnt = (m == 0) ? LCC_CNT_RESET[15:0] : (m == 1) ? LCC_CNT_PRESET[15:0] : LCC_UNDEF_FILL[15:0];
         post = (m == 1) ? 16'h0 : ld[15:0];
         post2 = (m == 0) ? ld[15:0] : 16'h0;
         chain <= '1;
         wr(LCC_LOAD_OFS, ld);
         wr(LCC_CTRL_OFS, ctl);
         tick(3);
         chkb(cho, 1'b1);
         chip_rst_n <= 1'b0;
         clr <= (m == 2);
         tick(6);
         chk({16'h0, cnt}, {16'h0, exp_cnt});
         chkb(cho, 1'b0);
         chk({16'h0, cnt2}, {16'h0, post2});
         chkb(cho2, 1'b1);
         bus(1'b0, LCC_CTRL_OFS, 32'h0, rq, re);
         chk(rq, ctl);
         chip_rst_n <= 1'b1;
         clr <= 1'b0;
         tick(6);
         chk({16'h0, cnt}, {16'h0, post});
      end
      $display("test chip reset done");
      ld = $urandom();
      wr(LCC_LOAD_OFS, ld);
      wr(LCC_CTRL_OFS, 32'h28);
      pre <= 1'b1;
      tick(6);
      chk({16'h0, cnt}, {16'h0, LCC_CNT_PRESET[15:0]});
      clr <= 1'b1;
      tick(6);
      chk({16'h0, cnt}, 32'h0);
      clr <= 1'b0;
      pre <= 1'b0;
      tick(6);
      chk({16'h0, cnt}, {16'h0, ld[15:0]});
      $display("test cluster clear and preset done");
      test_done();
   end
endmodule
